// *** logic/epio_port.sv ***
/*
 Eight-pin general-purpose I/O port with direction and level registers,
 pins shared with processor-state and trace-nibble emulation outputs.
 Assumes the pin function select bits and emulation signals come from logic on
 clk_sys_in; the pin pad combines level, output and enable outside this block.
*/
`timescale 1ns/1ns
module epio_port (
    input wire logic clk_sys_in,
    input wire logic rst_in,
    input wire logic ce_in,
    input wire epio_pkg::epio_reg_req_t reg_req_in,
    output epio_pkg::epio_reg_resp_t reg_resp_out,
    input wire logic [epio_pkg::EPIO_PINS-1:0] pin_function_select_in,
    input wire epio_pkg::epio_emu_t emu_in,
    input wire logic [epio_pkg::EPIO_PINS-1:0] gpio_pin_in,
    output logic [epio_pkg::EPIO_PINS-1:0] gpio_pin_out,
    output logic [epio_pkg::EPIO_PINS-1:0] gpio_pin_oe_out
);

    logic [epio_pkg::EPIO_DATA_W-1:0] pin_direction_control_r;
    logic [epio_pkg::EPIO_DATA_W-1:0] pin_level_r;
    logic [epio_pkg::EPIO_PINS-1:0] pin_sync;
    logic [epio_pkg::EPIO_PINS-1:0] emu_vec;
    logic [epio_pkg::EPIO_PINS-1:0] pin_out_nxt;
    logic [epio_pkg::EPIO_PINS-1:0] pin_oe_nxt;
    logic [epio_pkg::EPIO_DATA_W-1:0] rdata_nxt;
    logic hit_dir;
    logic hit_level;
    logic wr_dir;
    logic wr_level;

    // Address compare used by both read and write decode
    function automatic logic offset_hit(
        input logic [epio_pkg::EPIO_ADDR_W-1:0] addr,
        input logic [epio_pkg::EPIO_ADDR_W-1:0] ofs
    );
        offset_hit = (addr == ofs);
    endfunction

    // Per-bit select between a general-purpose value and a shared value
    function automatic logic [epio_pkg::EPIO_PINS-1:0] pick(
        input logic [epio_pkg::EPIO_PINS-1:0] sel,
        input logic [epio_pkg::EPIO_PINS-1:0] when_one,
        input logic [epio_pkg::EPIO_PINS-1:0] when_zero
    );
        pick = (sel & when_one) | (~sel & when_zero);
    endfunction

    epio_sync2 u_sync (
        .clk_sys_in(clk_sys_in),
        .rst_in(rst_in),
        .ce_in(ce_in),
        .async_in(gpio_pin_in),
        .sync_out(pin_sync)
    );

    // Shared emulation signals laid onto pin positions
    always_comb begin
        emu_vec = '0;
        emu_vec[epio_pkg::EPIO_TRACE_LSB +: epio_pkg::EPIO_EMU_W] = emu_in.trace;
        emu_vec[epio_pkg::EPIO_STATE_LSB +: epio_pkg::EPIO_EMU_W] = emu_in.state;
    end

    // Only the two printed offsets decode; anything else is a no-op answered with hit low
    always_comb begin
        hit_dir = offset_hit(reg_req_in.addr, epio_pkg::EPIO_OFS_DIR);
        hit_level = offset_hit(reg_req_in.addr, epio_pkg::EPIO_OFS_LEVEL);
        wr_dir = reg_req_in.valid && reg_req_in.write && hit_dir;
        wr_level = reg_req_in.valid && reg_req_in.write && hit_level;
    end

    // Direction register: one bit per pin
    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            pin_direction_control_r <= epio_pkg::EPIO_DIR_RST;
        end else if (ce_in && wr_dir) begin
            pin_direction_control_r <= reg_req_in.wdata;
        end
    end

    // Level register stores every write, whatever the direction
    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            pin_level_r <= epio_pkg::EPIO_LEVEL_RST;
        end else if (ce_in && wr_level) begin
            pin_level_r <= reg_req_in.wdata;
        end
    end

    // Pin drive: general-purpose pins follow the registers, others carry emulation
    always_comb begin
        pin_out_nxt = pick(pin_function_select_in, pin_level_r, emu_vec);
        // Emulation pins always drive, so direction has no say there
        pin_oe_nxt = pick(pin_function_select_in, pin_direction_control_r, '1);
    end

    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            gpio_pin_out <= epio_pkg::EPIO_SYNC_RST;
            gpio_pin_oe_out <= epio_pkg::EPIO_SYNC_RST;
        end else if (ce_in) begin
            gpio_pin_out <= pin_out_nxt;
            gpio_pin_oe_out <= pin_oe_nxt;
        end
    end

    // Readback: outputs show the driven value, inputs the synchronised pin.
    // Emulation pins return the pin level, which software must not trust.
    always_comb begin
        rdata_nxt = epio_pkg::EPIO_RDATA_ZERO;
        if (hit_dir) begin
            rdata_nxt = pin_direction_control_r;
        end else if (hit_level) begin
            rdata_nxt = pick(pin_direction_control_r & pin_function_select_in,
                             pin_level_r, pin_sync);
        end
    end

    // One response pulse per request, the cycle after it is taken
    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            reg_resp_out <= '0;
        end else if (ce_in) begin
            reg_resp_out.valid <= reg_req_in.valid;
            reg_resp_out.hit <= reg_req_in.valid && (hit_dir || hit_level);
            if (reg_req_in.valid && !reg_req_in.write) begin
                reg_resp_out.rdata <= rdata_nxt;
            end else begin
                reg_resp_out.rdata <= epio_pkg::EPIO_RDATA_ZERO;
            end
        end
    end

endmodule

// *** logic/epio_pkg.sv ***
/*
 Package for the eight-pin parallel I/O port: register offsets, reset values,
 pin sharing layout and the packed carriers used at the port's boundary.
 Assumes a single system clock domain and that every user names items as epio_pkg::name.
*/
package epio_pkg;

    localparam int unsigned EPIO_PINS = 8;
    localparam int unsigned EPIO_ADDR_W = 10;
    localparam int unsigned EPIO_DATA_W = 8;

    // Offsets from the module base pointer
    localparam logic [EPIO_ADDR_W-1:0] EPIO_OFS_DIR = 10'h1c5;
    localparam logic [EPIO_ADDR_W-1:0] EPIO_OFS_LEVEL = 10'h1c9;

    localparam logic [EPIO_DATA_W-1:0] EPIO_DIR_RST = 8'h00;
    localparam logic [EPIO_DATA_W-1:0] EPIO_LEVEL_RST = 8'h00;
    localparam logic [EPIO_DATA_W-1:0] EPIO_RDATA_ZERO = 8'h00;
    localparam logic [EPIO_PINS-1:0] EPIO_SYNC_RST = 8'h00;

    // Direction encoding of one bit
    localparam logic EPIO_DIR_IN = 1'b0;
    localparam logic EPIO_DIR_OUT = 1'b1;

    // Pin sharing: processor state on pins 3..0, trace nibble on pins 7..4
    localparam int unsigned EPIO_STATE_LSB = 0;
    localparam int unsigned EPIO_TRACE_LSB = 4;
    localparam int unsigned EPIO_EMU_W = 4;

    typedef struct packed {
        logic valid;
        logic write;
        logic [EPIO_ADDR_W-1:0] addr;
        logic [EPIO_DATA_W-1:0] wdata;
    } epio_reg_req_t;

    typedef struct packed {
        logic valid;
        logic hit;
        logic [EPIO_DATA_W-1:0] rdata;
    } epio_reg_resp_t;

    typedef struct packed {
        logic [EPIO_EMU_W-1:0] trace;
        logic [EPIO_EMU_W-1:0] state;
    } epio_emu_t;

endpackage

// *** logic/epio_sync2.sv ***
/*
 Two-stage synchroniser for the eight pin levels.
 Assumes the pins change without regard to clk_sys_in; only the second stage is read outside.
*/
`timescale 1ns/1ns
module epio_sync2 (
    input wire logic clk_sys_in,
    input wire logic rst_in,
    input wire logic ce_in,
    input wire logic [epio_pkg::EPIO_PINS-1:0] async_in,
    output logic [epio_pkg::EPIO_PINS-1:0] sync_out
);

    logic [epio_pkg::EPIO_PINS-1:0] meta_r;

    // First stage feeds only the second stage
    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            meta_r <= epio_pkg::EPIO_SYNC_RST;
            sync_out <= epio_pkg::EPIO_SYNC_RST;
        end else if (ce_in) begin
            meta_r <= async_in;
            sync_out <= meta_r;
        end
    end

endmodule

// *** test/epio_port_sva.sv ***
/* Checker for the eight-pin I/O port: register answers and pin drive.
 Assumes it sees only the port's pins; bound at the foot of this file. */
`timescale 1ns/1ns
module epio_port_sva (
    input wire logic clk_sys_in,
    input wire logic rst_in,
    input wire logic ce_in,
    input wire epio_pkg::epio_reg_req_t reg_req_in,
    input wire epio_pkg::epio_reg_resp_t reg_resp_out,
    input wire logic [7:0] pin_function_select_in,
    input wire epio_pkg::epio_emu_t emu_in,
    input wire logic [7:0] gpio_pin_in,
    input wire logic [7:0] gpio_pin_out,
    input wire logic [7:0] gpio_pin_oe_out
);
    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (rst_in);
    wire logic v = ce_in && reg_req_in.valid;
    wire logic w = v && reg_req_in.write;
    wire logic [9:0] a = reg_req_in.addr;
    wire logic [7:0] s = pin_function_select_in;
    chk_resp_follows_req: assert property (v |=> reg_resp_out.valid) else $error("no answer");
    chk_resp_idle_quiet: assert property (ce_in && !reg_req_in.valid |=> !reg_resp_out.valid) else $error("stray answer");
    chk_hit_decode: assert property (v |=> reg_resp_out.hit == ($past(a) inside {10'h1c5, 10'h1c9})) else $error("bad hit");
    chk_zero_read_back: assert property (v && (reg_req_in.write || !(a inside {10'h1c5, 10'h1c9}))
        |=> reg_resp_out.rdata == 8'h00) else $error("nonzero data");
    // Reset must clear drive even though the default disable would hide it
    chk_reset_clears_drive: assert property (disable iff (1'b0) rst_in && ce_in
        |=> gpio_pin_oe_out == 8'h00 && !reg_resp_out.valid) else $error("reset drive");
    chk_emu_owns_oe: assert property (ce_in |=> (~gpio_pin_oe_out & ~$past(s)) == 8'h00) else $error("emu oe");
    chk_emu_pin_value: assert property (ce_in |=> ((gpio_pin_out ^ $past(emu_in)) & ~$past(s)) == 8'h00)
        else $error("emu value");
    chk_level_to_pin: assert property (w && a == 10'h1c9 ##1 ce_in [*2]
        |-> ((gpio_pin_out ^ $past(reg_req_in.wdata, 2)) & gpio_pin_oe_out & $past(s)) == 8'h00)
        else $error("level drive");
    chk_dir_to_oe: assert property (w && a == 10'h1c5 ##1 ce_in [*2]
        |-> gpio_pin_oe_out == ($past(reg_req_in.wdata, 2) | ~$past(s))) else $error("dir oe");
    cover property (w && a == 10'h1c9);
    cover property (v && !reg_req_in.write && a == 10'h1c5);
    cover property (ce_in && s != 8'hff);
endmodule
bind epio_port epio_port_sva u_epio_port_sva (.clk_sys_in, .rst_in, .ce_in, .reg_req_in, .reg_resp_out,
    .pin_function_select_in, .emu_in, .gpio_pin_in, .gpio_pin_out, .gpio_pin_oe_out);

// *** test/epio_board.sv ***
/* Board model for the eight shared pins.
 Assumes the port's drive and enable; drives a chosen level elsewhere. */
`timescale 1ns/1ns
module epio_board (
    input wire logic [7:0] pin_drive_in,
    input wire logic [7:0] pin_oe_in,
    input wire logic [7:0] board_level_in,
    output logic [7:0] pin_level_out
);
    // The port wins where it drives, so the board never fights it
    assign pin_level_out = (pin_drive_in & pin_oe_in) | (board_level_in & ~pin_oe_in);
endmodule

// *** test/epio_port_bench.sv ***
/* Bench for the eight-pin I/O port: register accesses and pin levels.
 Assumes the board model and the bound checker are compiled alongside. */
`timescale 1ns/1ns
module epio_port_bench;
    logic clk_sys_in = 0;
    logic rst_in = 1;
    logic ce = 1;
    epio_pkg::epio_reg_req_t req = '0;
    epio_pkg::epio_reg_resp_t resp;
    logic [7:0] sel = 8'hff;
    epio_pkg::epio_emu_t emu = '0;
    logic [7:0] brd = 8'h00;
    logic [7:0] pin_i, pin_o, pin_oe;
    int fails = 0;
    int checked = 0;
    initial forever #50 clk_sys_in = ~clk_sys_in;
    epio_port u_epio_port (.clk_sys_in, .rst_in, .ce_in(ce), .reg_req_in(req), .reg_resp_out(resp),
        .pin_function_select_in(sel), .emu_in(emu), .gpio_pin_in(pin_i), .gpio_pin_out(pin_o),
        .gpio_pin_oe_out(pin_oe));
    epio_board u_epio_board (.pin_drive_in(pin_o), .pin_oe_in(pin_oe), .board_level_in(brd),
        .pin_level_out(pin_i));
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            fails++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // One access: request held over one edge, answer taken a cycle later
    task automatic acc(input logic wr, input logic [9:0] a, input logic [7:0] d, output logic [7:0] q);
        @(negedge clk_sys_in);
        req = '{1'b1, wr, a, d};
        @(negedge clk_sys_in);
        req = '0;
        chk({7'h00, resp.valid}, 8'h01);
        chk({7'h00, resp.hit}, {7'h00, (a == epio_pkg::EPIO_OFS_DIR) || (a == epio_pkg::EPIO_OFS_LEVEL)});
        q = resp.rdata;
    endtask
    task automatic wr(input logic [9:0] a, input logic [7:0] d);
        logic [7:0] q;
        acc(1'b1, a, d, q);
        chk(q, 8'h00);
    endtask
    task automatic rd(input logic [9:0] a, input logic [7:0] exp);
        logic [7:0] q;
        acc(1'b0, a, 8'h00, q);
        chk(q, exp);
    endtask
    task automatic print_verdict;
        $display("Comparisons %0d, mismatches %0d", checked, fails);
        if (fails == 0 && checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    initial begin
        repeat (12) @(negedge clk_sys_in);
        rst_in = 0;
        rd(10'h1c5, 8'h00);
        rd(10'h1c9, 8'h00);
        wr(10'h1c6, 8'hff);
        rd(10'h1c6, 8'h00);
        rd(10'h1c5, 8'h00);
        brd = 8'h3c;
        wr(10'h1c9, 8'ha5);
        rd(10'h1c9, 8'h3c);
        wr(10'h1c5, 8'hff);
        rd(10'h1c9, 8'ha5);
        chk(pin_o, 8'ha5);
        chk(pin_oe, 8'hff);
        wr(10'h1c5, 8'h0f);
        rd(10'h1c5, 8'h0f);
        rd(10'h1c9, 8'h35);
        // Emulation pins carry the trace nibble and stay driven whatever the direction register holds
        sel = 8'h0f;
        emu = '{4'h9, 4'h6};
        repeat (2) @(negedge clk_sys_in);
        chk(pin_oe, 8'hff);
        chk(pin_o, 8'h95);
        wr(10'h1c5, 8'h00);
        @(negedge clk_sys_in);
        chk(pin_oe, 8'hf0);
        // Clock enable low must freeze the register port and drop the request
        ce = 0;
        req = '{1'b1, 1'b1, 10'h1c5, 8'h55};
        repeat (2) @(negedge clk_sys_in);
        chk({7'h00, resp.valid}, 8'h00);
        req = '0;
        ce = 1;
        rd(10'h1c5, 8'h00);
        print_verdict;
    end
    initial begin
        repeat (400) @(posedge clk_sys_in);
        fails++;
        print_verdict;
    end
endmodule
